// *** rtl/rtcca_pkg.sv ***
// Constants, types and helper functions for the calendar, alarm and control core
// Behaviour
// - Hours bit 5 is PM flag in 12-hour mode, twenty-hours digit in 24-hour.
// - Century bit 7 of month flips when year wraps 99 to 00.
// - Day of week advances at midnight, running 1 to 7 in sequence.
// - Time copied into read buffer on START and on pointer wrap to zero.
// - Writing seconds resets sub-second chain; each byte acts when acknowledged.
// - 1Hz wave goes high 500ms after seconds byte is written.
// - Two alarms, first at 07h to 0Ah, second at 0Bh to 0Dh.
// - Bit 7 of each alarm register masks that field from the match.
// - First alarm mask bits select once per second up to full match.
// - Second alarm fires per minute at 00 seconds, masks add fields.
// - Alarm bits 0 to 5 match date, or weekday when bit 6 set.
// - Match sets flag; pin asserts only with enable and interrupt mode.
// - Alarms are evaluated only on the once-per-second time update.
// - Oscillator stop bit halts counting only on battery; registers stay static.
// - On battery, wave only with battery wave enable and no interrupt mode.
// - Manual sample starts only when idle; 64-second schedule unchanged.
// - Sample bit reads one until done, clears with busy; busy waits 2ms.
// - Rate bits pick 1Hz, 1.024kHz, 4.096kHz or 8.192kHz; reset 11.
// - Interrupt mode bit selects wave or alarm interrupt; flags set regardless.
// - Alarm interrupt enables gate each flag onto the pin.
// - Alarm flags clear only on written zero; writing one leaves them.
// - Time and calendar registers are held in BCD.
package rtcca_pkg;
    // Register offsets
    localparam logic [7:0] REG_SEC = 8'h00;
    localparam logic [7:0] REG_YEAR = 8'h06;
    localparam logic [7:0] REG_AL1_FIRST = 8'h07;
    localparam logic [7:0] REG_AL1_LAST = 8'h0a;
    localparam logic [7:0] REG_AL2_FIRST = 8'h0b;
    localparam logic [7:0] REG_AL2_LAST = 8'h0d;
    localparam logic [7:0] REG_CONTROL = 8'h0e;
    localparam logic [7:0] REG_STATUS = 8'h0f;
    localparam logic [7:0] PTR_LAST = 8'hff;
    // Control fields and reset
    localparam logic [7:0] CONTROL_RESET = 8'h1c;
    localparam int CTL_OSC_STOP = 7;
    localparam int CTL_BATT_WAVE = 6;
    localparam int CTL_SAMPLE = 5;
    localparam int CTL_RATE_LO = 3;
    localparam int CTL_IRQ_MODE = 2;
    localparam int CTL_A2_IE = 1;
    localparam int CTL_A1_IE = 0;
    // Status fields
    localparam int ST_BUSY = 2;
    localparam int ST_A2F = 1;
    localparam int ST_A1F = 0;
    // Time fields
    localparam int HR_12_MODE = 6;
    localparam int HR_PM_OR_20 = 5;
    localparam int MON_CENTURY = 7;
    localparam int AL_MASK = 7;
    localparam int AL_WEEKDAY = 6;
    // Timebase and timing
    localparam int MCLK_HZ = 40_000_000;
    localparam int BUSY_HOLD_US = 2000;
    localparam int BUSY_HOLD_CYC = MCLK_HZ / 1_000_000 * BUSY_HOLD_US;
    localparam int SAMPLE_US = 1000;
    localparam int SAMPLE_CYC = MCLK_HZ / 1_000_000 * SAMPLE_US;
    localparam logic [5:0] PERIOD_SEC_LAST = 6'd63;
    localparam logic [14:0] PRESC_LAST = 15'h7fff;
    localparam logic [7:0] TIME_RESET = 8'h00;
    localparam logic [7:0] ONE_BCD = 8'h01;

    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_WADDR = 2'b01,
        OP_WDATA = 2'b11,
        OP_READ = 2'b10
    } rtcca_op_e;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_HOLD = 2'b01,
        CV_RUN = 2'b11
    } rtcca_manual_temp_sample_e;

    // BCD increment of a two-digit value
    function automatic logic [7:0] rtcca_bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            rtcca_bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            rtcca_bcd_inc = v + 8'h01;
        end
    endfunction : rtcca_bcd_inc

    // Last BCD date of a month, leap years every fourth year
    function automatic logic [7:0] rtcca_last_date(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == 5'h02) begin
            rtcca_last_date = leap ? 8'h29 : 8'h28;
        end else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
            rtcca_last_date = 8'h30;
        end else begin
            rtcca_last_date = 8'h31;
        end
    endfunction : rtcca_last_date
endpackage : rtcca_pkg

// *** rtl/rtcca_link.sv ***
// Link-clock side of the register channel: one request in flight, toggle handshake
`timescale 1ns/1ps
module rtcca_link
    import rtcca_pkg::*;
(
    // Link clock and reset
    input wire logic i_link_clk,
    input wire logic i_reset_n,
    // Link byte channel
    input wire logic i_link_valid,
    input wire logic [1:0] i_link_op,
    input wire logic [7:0] i_link_data,
    output logic o_link_ready,
    output logic o_link_rvalid,
    output logic [7:0] o_link_rdata,
    // Crossing towards the core
    output logic o_req_tgl,
    output logic [1:0] o_req_op,
    output logic [7:0] o_req_data,
    input wire logic i_ack_tgl,
    input wire logic [7:0] i_ack_data
);
    logic ack_s1;
    logic ack_s2;

    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= i_ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // Payload holds still until the core answers, so it crosses as a word
    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_req_tgl <= 1'b0;
            o_req_op <= OP_START;
            o_req_data <= 8'h00;
            o_link_ready <= 1'b1;
            o_link_rvalid <= 1'b0;
            o_link_rdata <= 8'h00;
        end else begin
            o_link_rvalid <= 1'b0;
            if (o_link_ready && i_link_valid) begin
                o_req_op <= i_link_op;
                o_req_data <= i_link_data;
                o_req_tgl <= ~o_req_tgl;
                o_link_ready <= 1'b0;
            end else if (!o_link_ready && ack_s2 == o_req_tgl) begin
                o_link_ready <= 1'b1;
                o_link_rvalid <= (o_req_op == OP_READ);
                o_link_rdata <= i_ack_data;
            end
        end
    end
endmodule : rtcca_link

// *** rtl/rtcca_core.sv ***
// Calendar, alarms, control register and wave/interrupt pin of the clock core
`timescale 1ns/1ps
module rtcca_core
    import rtcca_pkg::*;
#(
    parameter int unsigned P_HOLD_CYC = BUSY_HOLD_CYC,
    parameter int unsigned P_SAMPLE_CYC = SAMPLE_CYC
) (
    // Core clock and reset
    input wire logic i_mclk,
    input wire logic i_reset_n,
    // Timebase and supply state pins
    input wire logic i_tick_32k,
    input wire logic i_on_battery,
    // Link byte channel
    input wire logic i_link_clk,
    input wire logic i_link_valid,
    input wire logic [1:0] i_link_op,
    input wire logic [7:0] i_link_data,
    output logic o_link_ready,
    output logic o_link_rvalid,
    output logic [7:0] o_link_rdata,
    // Shared interrupt and wave pin, open drain
    output logic o_irq_wave_pin_o,
    output logic o_irq_wave_pin_oe
);
    logic req_tgl;
    logic [1:0] req_op;
    logic [7:0] req_data;
    logic ack_tgl;
    logic [7:0] ack_data;
    logic req_s1, req_s2, req_s3;
    logic tick_s1, tick_s2, tick_s3;
    logic batt_s1, on_batt;
    logic [14:0] presc;
    logic [7:0] sec, min, hour, dow, date, mon, year;
    logic [7:0] next_sec, next_min, next_hour, next_dow, next_date, next_mon, next_year;
    logic [7:0] al1 [0:3];
    logic [7:0] al2 [0:2];
    logic [7:0] shadow [0:6];
    logic [7:0] ctrl;
    logic [7:0] ptr;
    logic a1f, a2f;
    logic sec_tick, eval;
    logic [5:0] period_cnt;
    logic [31:0] cv_cnt;
    rtcca_manual_temp_sample_e cv_state;
    logic svc, wr, osc_run, wave;
    logic a1_hit, a2_hit, snap;

    rtcca_link u_link (
        .i_link_clk(i_link_clk),
        .i_reset_n(i_reset_n),
        .i_link_valid(i_link_valid),
        .i_link_op(i_link_op),
        .i_link_data(i_link_data),
        .o_link_ready(o_link_ready),
        .o_link_rvalid(o_link_rvalid),
        .o_link_rdata(o_link_rdata),
        .o_req_tgl(req_tgl),
        .o_req_op(req_op),
        .o_req_data(req_data),
        .i_ack_tgl(ack_tgl),
        .i_ack_data(ack_data)
    );

    // Pins and the request toggle pass two flops before use
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {req_s1, req_s2, req_s3} <= 3'b000;
            {tick_s1, tick_s2, tick_s3} <= 3'b000;
            {batt_s1, on_batt} <= 2'b00;
        end else begin
            {req_s1, req_s2, req_s3} <= {req_tgl, req_s1, req_s2};
            {tick_s1, tick_s2, tick_s3} <= {i_tick_32k, tick_s1, tick_s2};
            {batt_s1, on_batt} <= {i_on_battery, batt_s1};
        end
    end

    assign svc = req_s2 ^ req_s3;
    assign wr = svc && (req_op == OP_WDATA);
    assign osc_run = !(on_batt && ctrl[CTL_OSC_STOP]);
    assign sec_tick = osc_run && tick_s2 && !tick_s3 && presc == PRESC_LAST;
    assign snap = svc && (req_op == OP_START || ((req_op == OP_WDATA || req_op == OP_READ) && ptr == PTR_LAST));

    // Sub-second chain; cleared by a seconds write so the wave edge lands half a second later
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            presc <= 15'h0000;
        end else if (wr && ptr == REG_SEC) begin
            presc <= 15'h0000;
        end else if (osc_run && tick_s2 && !tick_s3) begin
            presc <= presc + 15'h0001;
        end
    end

    // Next calendar values, all in BCD
    always_comb begin
        logic day_carry, mon_carry, yr_carry;
        logic [7:0] inc_hr12, inc_hr24, inc_mon;
        day_carry = 1'b0;
        inc_hr12 = rtcca_bcd_inc({3'b000, hour[4:0]});
        inc_hr24 = rtcca_bcd_inc({2'b00, hour[5:0]});
        inc_mon = rtcca_bcd_inc({3'b000, mon[4:0]});
        next_sec = (sec == 8'h59) ? TIME_RESET : rtcca_bcd_inc(sec);
        next_min = min;
        next_hour = hour;
        if (sec == 8'h59) begin
            next_min = (min == 8'h59) ? TIME_RESET : rtcca_bcd_inc(min);
        end
        if (sec == 8'h59 && min == 8'h59) begin
            if (hour[HR_12_MODE]) begin
                if (hour[4:0] == 5'h12) begin
                    next_hour = {hour[7:5], 5'h01};
                end else if (hour[4:0] == 5'h11) begin
                    next_hour = {hour[7:6], ~hour[HR_PM_OR_20], 5'h12};
                    day_carry = hour[HR_PM_OR_20];
                end else begin
                    next_hour = {hour[7:5], inc_hr12[4:0]};
                end
            end else if (hour[5:0] == 6'h23) begin
                next_hour = {hour[7:6], 6'h00};
                day_carry = 1'b1;
            end else begin
                next_hour = {hour[7:6], inc_hr24[5:0]};
            end
        end
        mon_carry = day_carry && date == rtcca_last_date(mon[4:0], year);
        yr_carry = mon_carry && mon[4:0] == 5'h12;
        next_dow = dow;
        next_date = date;
        next_mon = mon;
        next_year = year;
        if (day_carry) begin
            next_dow = (dow == 8'h07) ? ONE_BCD : rtcca_bcd_inc(dow);
            next_date = mon_carry ? ONE_BCD : rtcca_bcd_inc(date);
        end
        if (mon_carry) begin
            next_mon = yr_carry ? {mon[7:5], 5'h01} : {mon[7:5], inc_mon[4:0]};
        end
        if (yr_carry) begin
            next_year = (year == 8'h99) ? TIME_RESET : rtcca_bcd_inc(year);
            if (year == 8'h99) begin
                next_mon[MON_CENTURY] = ~mon[MON_CENTURY];
            end
        end
    end

    // Live time; a byte written in a tick cycle overrides only its own register
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {sec, min, hour, dow, date, mon, year} <= {7{TIME_RESET}};
        end else begin
            if (sec_tick) begin
                {sec, min, hour, dow, date, mon, year} <=
                    {next_sec, next_min, next_hour, next_dow, next_date, next_mon, next_year};
            end
            if (wr) begin
                unique case (ptr)
                    8'h00: sec <= req_data;
                    8'h01: min <= req_data;
                    8'h02: hour <= req_data;
                    8'h03: dow <= req_data;
                    8'h04: date <= req_data;
                    8'h05: mon <= req_data;
                    8'h06: year <= req_data;
                    default: ;
                endcase
            end
        end
    end

    // Alarm registers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 4; i++) begin
                al1[i] <= 8'h00;
            end
            for (int i = 0; i < 3; i++) begin
                al2[i] <= 8'h00;
            end
        end else if (wr && ptr >= REG_AL1_FIRST && ptr <= REG_AL1_LAST) begin
            al1[2'(ptr - REG_AL1_FIRST)] <= req_data;
        end else if (wr && ptr >= REG_AL2_FIRST && ptr <= REG_AL2_LAST) begin
            al2[2'(ptr - REG_AL2_FIRST)] <= req_data;
        end
    end

    // Pointer, read buffer and answer; reads never see a half-updated time
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr <= 8'h00;
            ack_tgl <= 1'b0;
            ack_data <= 8'h00;
            for (int i = 0; i < 7; i++) begin
                shadow[i] <= 8'h00;
            end
        end else if (svc) begin
            ack_tgl <= ~ack_tgl;
            if (snap) begin
                {shadow[0], shadow[1], shadow[2], shadow[3], shadow[4], shadow[5], shadow[6]} <=
                    {sec, min, hour, dow, date, mon, year};
            end
            if (req_op == OP_WADDR) begin
                ptr <= req_data;
            end else if (req_op != OP_START) begin
                ptr <= ptr + 8'h01;
            end
            if (ptr <= REG_YEAR) begin
                ack_data <= shadow[3'(ptr)];
            end else if (ptr <= REG_AL1_LAST) begin
                ack_data <= al1[2'(ptr - REG_AL1_FIRST)];
            end else if (ptr <= REG_AL2_LAST) begin
                ack_data <= al2[2'(ptr - REG_AL2_FIRST)];
            end else if (ptr == REG_CONTROL) begin
                ack_data <= ctrl;
            end else if (ptr == REG_STATUS) begin
                ack_data <= {5'h00, cv_state == CV_RUN, a2f, a1f};
            end else begin
                ack_data <= 8'h00;
            end
        end
    end

    // Alarm matching against the freshly updated time
    always_comb begin
        logic [7:0] dd1, dd2;
        dd1 = al1[3][AL_WEEKDAY] ? dow : date;
        dd2 = al2[2][AL_WEEKDAY] ? dow : date;
        a1_hit = (al1[0][AL_MASK] || al1[0][6:0] == sec[6:0])
            && (al1[1][AL_MASK] || al1[1][6:0] == min[6:0])
            && (al1[2][AL_MASK] || al1[2][6:0] == hour[6:0])
            && (al1[3][AL_MASK] || al1[3][5:0] == dd1[5:0]);
        a2_hit = sec == 8'h00
            && (al2[0][AL_MASK] || al2[0][6:0] == min[6:0])
            && (al2[1][AL_MASK] || al2[1][6:0] == hour[6:0])
            && (al2[2][AL_MASK] || al2[2][5:0] == dd2[5:0]);
    end

    // Flags: a match in the clearing cycle still sets the flag
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            eval <= 1'b0;
            a1f <= 1'b0;
            a2f <= 1'b0;
        end else begin
            eval <= sec_tick;
            if (wr && ptr == REG_STATUS && !req_data[ST_A1F]) begin
                a1f <= 1'b0;
            end
            if (wr && ptr == REG_STATUS && !req_data[ST_A2F]) begin
                a2f <= 1'b0;
            end
            if (eval && a1_hit) begin
                a1f <= 1'b1;
            end
            if (eval && a2_hit) begin
                a2f <= 1'b1;
            end
        end
    end

    // Control register; the sample bit is owned by the conversion sequencer
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl <= CONTROL_RESET;
        end else begin
            if (wr && ptr == REG_CONTROL) begin
                ctrl <= {req_data[7:6], ctrl[CTL_SAMPLE], req_data[4:0]};
                if (req_data[CTL_SAMPLE] && cv_state == CV_IDLE) begin
                    ctrl[CTL_SAMPLE] <= 1'b1;
                end
            end
            if (cv_state == CV_RUN && cv_cnt == 32'(P_SAMPLE_CYC - 1) && ctrl[CTL_SAMPLE]) begin
                ctrl[CTL_SAMPLE] <= 1'b0;
            end
        end
    end

    // Compensation sequencer: periodic every 64 s, manual waits before busy shows
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cv_state <= CV_IDLE;
            cv_cnt <= 32'h0;
            period_cnt <= 6'h00;
        end else begin
            if (sec_tick) begin
                period_cnt <= (period_cnt == PERIOD_SEC_LAST) ? 6'h00 : period_cnt + 6'h01;
            end
            unique case (cv_state)
                CV_IDLE: begin
                    cv_cnt <= 32'h0;
                    if (wr && ptr == REG_CONTROL && req_data[CTL_SAMPLE]) begin
                        cv_state <= CV_HOLD;
                    end else if (sec_tick && period_cnt == PERIOD_SEC_LAST) begin
                        cv_state <= CV_RUN;
                    end
                end
                CV_HOLD: begin
                    cv_cnt <= cv_cnt + 32'h1;
                    if (cv_cnt == 32'(P_HOLD_CYC - 1)) begin
                        cv_cnt <= 32'h0;
                        cv_state <= CV_RUN;
                    end
                end
                CV_RUN: begin
                    cv_cnt <= cv_cnt + 32'h1;
                    if (cv_cnt == 32'(P_SAMPLE_CYC - 1)) begin
                        cv_state <= CV_IDLE;
                    end
                end
                default: cv_state <= CV_IDLE;
            endcase
        end
    end

    // Wave tap from the sub-second chain
    always_comb begin
        unique case (ctrl[4:3])
            2'b00: wave = presc[14];
            2'b01: wave = presc[4];
            2'b10: wave = presc[2];
            default: wave = presc[1];
        endcase
    end

    // Open-drain pin: low means interrupt or wave low, released means high
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq_wave_pin_o <= 1'b0;
            o_irq_wave_pin_oe <= 1'b0;
        end else begin
            o_irq_wave_pin_o <= 1'b0;
            if (ctrl[CTL_IRQ_MODE]) begin
                o_irq_wave_pin_oe <= (a1f && ctrl[CTL_A1_IE]) || (a2f && ctrl[CTL_A2_IE]);
            end else if (on_batt && !ctrl[CTL_BATT_WAVE]) begin
                o_irq_wave_pin_oe <= 1'b0;
            end else begin
                o_irq_wave_pin_oe <= !wave;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_irq_enabled: assert property ((ctrl[CTL_IRQ_MODE] && a1f && ctrl[CTL_A1_IE]) |=> o_irq_wave_pin_oe)
        else $error("enabled alarm flag did not pull the pin low");
    a_batt_release: assert property ((on_batt && !ctrl[CTL_BATT_WAVE] && !ctrl[CTL_IRQ_MODE]) |=> !o_irq_wave_pin_oe)
        else $error("pin driven on battery without battery wave enable");
    a_flag_clear: assert property ($fell(a1f) |-> $past(wr && ptr == REG_STATUS && !req_data[ST_A1F]))
        else $error("alarm flag cleared without a written zero");
    a_flag_at_tick: assert property ($rose(a2f) |-> $past(eval))
        else $error("alarm flag set outside the seconds update");
    a_presc_reset: assert property ((wr && ptr == REG_SEC) |=> presc == 15'h0000)
        else $error("seconds write did not reset the sub-second chain");
    a_osc_static: assert property ((!osc_run && !wr) |=> $stable(sec) && $stable(presc))
        else $error("time moved while oscillator stopped");
    a_century_flip: assert property ((sec_tick && !wr && year == 8'h99 && next_year == 8'h00)
        |=> mon[MON_CENTURY] != $past(mon[MON_CENTURY]))
        else $error("century bit did not flip at year wrap");
    a_sample_busy: assert property ($fell(ctrl[CTL_SAMPLE]) |-> $past(cv_state) == CV_RUN && cv_state == CV_IDLE)
        else $error("sample bit cleared apart from the busy flag");
    a_busy_hold: assert property ((cv_state == CV_IDLE && wr && ptr == REG_CONTROL && req_data[CTL_SAMPLE])
        |=> cv_state == CV_HOLD [*8])
        else $error("busy shown too soon after a manual sample");
    a_snap_start: assert property ((svc && req_op == OP_START) |=> shadow[0] == $past(sec))
        else $error("read buffer not loaded on start");
endmodule : rtcca_core

// *** dv/rtcca_host.sv ***
// Bus host model that drives the link byte channel
`timescale 1ns/1ps
module rtcca_host
    import rtcca_pkg::*;
(
    // Link clock and answers
    input wire logic i_link_clk,
    input wire logic i_ready,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    // Requests
    output logic o_valid,
    output logic [1:0] o_op,
    output logic [7:0] o_data
);
    initial begin
        o_valid = 1'b0;
        o_op = OP_START;
        o_data = 8'h00;
    end
    // Held until the edge that takes it; data turned over once released
    task automatic xfer(input logic [1:0] op, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(negedge i_link_clk);
        o_valid <= 1'b1;
        o_op <= op;
        o_data <= d;
        do @(posedge i_link_clk); while (i_ready !== 1'b1 && ++n < 50);
        @(negedge i_link_clk);
        o_valid <= 1'b0;
        o_data <= ~d;
        n = 0;
        do @(posedge i_link_clk); while ((op == OP_READ ? i_rvalid : i_ready) !== 1'b1 && ++n < 50);
        q = i_rdata;
    endtask : xfer
endmodule : rtcca_host

// *** dv/tb_top.sv ***
// Self-checking bench for the calendar, alarm and control core
`timescale 1ns/1ps
module tb_top;
    import rtcca_pkg::*;
    logic i_mclk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_tick_32k = 1'b0;
    logic batt = 1'b0;
    logic ready, rvalid, valid, oe, pin;
    logic [1:0] op;
    logic [7:0] rdata, wdata, q;
    logic [7:0] m [0:255];
    int n_fail = 0;
    int tests_run = 0;
    int seed = 56;
    int n;
    always #12.5 i_mclk = ~i_mclk;
    initial #7 forever #15 i_link_clk = ~i_link_clk;
    // Fast timebase: one second is 65536 core cycles
    always @(negedge i_mclk) i_tick_32k <= ~i_tick_32k;
    rtcca_core #(.P_HOLD_CYC(10), .P_SAMPLE_CYC(20)) i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_tick_32k(i_tick_32k), .i_on_battery(batt), .i_link_clk(i_link_clk), .i_link_valid(valid),
        .i_link_op(op), .i_link_data(wdata), .o_link_ready(ready), .o_link_rvalid(rvalid),
        .o_link_rdata(rdata), .o_irq_wave_pin_o(pin), .o_irq_wave_pin_oe(oe));
    rtcca_host i_host (.i_link_clk(i_link_clk), .i_ready(ready), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_valid(valid), .o_op(op), .o_data(wdata));
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(OP_START, 8'h00, q);
        i_host.xfer(OP_WADDR, a, q);
        i_host.xfer(OP_WDATA, d, q);
        m[a] = d;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] k);
        i_host.xfer(OP_START, 8'h00, q);
        i_host.xfer(OP_WADDR, a, q);
        i_host.xfer(OP_START, 8'h00, q);
        i_host.xfer(OP_READ, 8'h00, q);
        cmp("register", m[a] & k, q & k);
    endtask : rd_chk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    initial begin
        for (n = 0; n < 256; n++) m[n] = 8'h00;
        m[REG_CONTROL] = CONTROL_RESET;
        repeat (12) @(negedge i_mclk);
        i_reset_n = 1'b1;
        cmp("pin enable", 8'h00, {7'h0, oe});
        rd_chk(REG_CONTROL, 8'hff);
        rd_chk(8'h10, 8'hff);
        // First alarm keeps all masks set so it fires every second
        for (n = 7; n < 14; n++) wr(8'(n), 8'($random(seed)) | (n < 11 ? 8'h80 : 8'h00));
        wr(REG_CONTROL, 8'h05);
        for (n = 7; n < 15; n++) rd_chk(8'(n), 8'hff);
        wr(REG_SEC, 8'h00);
        n = 0;
        while (oe !== 1'b1 && n < 70000) begin
            @(negedge i_mclk);
            n++;
        end
        cmp("alarm lag", 8'h01, {7'h0, n > 65000 && n < 66200});
        m[REG_SEC] = ONE_BCD;
        m[REG_STATUS] = 8'h01;
        rd_chk(REG_SEC, 8'hff);
        rd_chk(REG_STATUS, 8'h03);
        wr(REG_STATUS, 8'h03);
        m[REG_STATUS] = 8'h01;
        rd_chk(REG_STATUS, 8'h03);
        cmp("pin enable", 8'h01, {7'h0, oe});
        wr(REG_CONTROL, 8'h04);
        repeat (4) @(negedge i_mclk);
        cmp("pin enable", 8'h00, {7'h0, oe});
        wr(REG_STATUS, 8'h00);
        rd_chk(REG_STATUS, 8'h03);
        rd_chk(REG_STATUS, 8'h04);
        wr(REG_CONTROL, 8'h24);
        m[REG_CONTROL] = 8'h04;
        rd_chk(REG_CONTROL, 8'hff);
        rd_chk(REG_STATUS, 8'h04);
        batt = 1'b1;
        wr(REG_CONTROL, 8'h80);
        repeat (8) @(negedge i_mclk);
        cmp("pin enable", 8'h00, {7'h0, oe});
        wrap_up();
    end
    initial begin
        #4_000_000;
        n_fail++;
        wrap_up();
    end
endmodule : tb_top
